/* File: design/sac_ctrl.sv */
/*
 * Host-side controller for a 128K x 24 asynchronous static memory: takes one
 * word request at a time and sequences selects, strobes, address and data.
 * Assumes the memory pins are timed by this clock and the data pins are
 * resolved outside from mem_data_oe.
 */
// Functional notes
// - select: first low, second high, third low
// - data stable 5.5 ns before write end
// - address set 7 ns before write end
// - select and strobe 7 ns, cycle 10 ns
// - write strobe high throughout reads
// - strobe write with enable low: float plus setup
// - wait 100 us after power before access
`timescale 1ns/1ps
module sac_ctrl
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic power_ready,
    output logic [ADDR_W-1:0] mem_addr,
    output logic chip_select_first_n,
    output logic chip_select_second_hi,
    output logic chip_select_third_n,
    output logic out_enable_n,
    output logic write_strobe_n,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe,
    input wire logic [DATA_W-1:0] mem_data_in
);
    sac_state_e state_r;
    sac_state_e state_nxt;
    logic accept;
    logic sel_nxt;

    sac_tmr_if tif ();

    sac_timer u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tif(tif)
    );

    assign accept = req_valid && req_ready;

    always_comb begin
        state_nxt = state_r;
        tif.load = 1'b0;
        tif.load_val = '0;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    tif.load = 1'b1;
                    if (req_write) begin
                        state_nxt = ST_W_SETUP;
                        tif.load_val = SETUP_CYC - TMR_W'(1);
                    end else begin
                        state_nxt = ST_R_ACCESS;
                        tif.load_val = ACCESS_CYC - TMR_W'(1);
                    end
                end
            end
            ST_W_SETUP: begin
                if (tif.done) begin
                    state_nxt = ST_W_STROBE;
                    tif.load = 1'b1;
                    tif.load_val = STROBE_CYC - TMR_W'(1);
                end
            end
            ST_W_STROBE: begin
                if (tif.done) begin
                    state_nxt = ST_W_HOLD;
                    tif.load = 1'b1;
                    tif.load_val = HOLD_CYC - TMR_W'(1);
                end
            end
            ST_W_HOLD: begin
                if (tif.done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_R_ACCESS: begin
                if (tif.done) begin
                    state_nxt = ST_R_RELEASE;
                    tif.load = 1'b1;
                    tif.load_val = RELEASE_CYC - TMR_W'(1);
                end
            end
            ST_R_RELEASE: begin
                if (tif.done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // no request taken before the power-up wait has run out
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_ready <= 1'b0;
            power_ready <= 1'b0;
        end else begin
            req_ready <= tif.pwr_ok && (state_nxt == ST_IDLE) && !accept;
            power_ready <= tif.pwr_ok;
        end
    end

    // selects stay active through the hold phase so the strobe ends the write
    assign sel_nxt = (state_nxt == ST_W_SETUP) || (state_nxt == ST_W_STROBE) ||
        (state_nxt == ST_W_HOLD) || (state_nxt == ST_R_ACCESS);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chip_select_first_n <= 1'b1;
            chip_select_second_hi <= 1'b0;
            chip_select_third_n <= 1'b1;
            write_strobe_n <= 1'b1;
            out_enable_n <= 1'b1;
            mem_data_oe <= 1'b0;
        end else begin
            chip_select_first_n <= !sel_nxt;
            chip_select_second_hi <= sel_nxt;
            chip_select_third_n <= !sel_nxt;
            write_strobe_n <= (state_nxt != ST_W_STROBE);
            out_enable_n <= (state_nxt != ST_R_ACCESS);
            mem_data_oe <= (state_nxt == ST_W_SETUP) || (state_nxt == ST_W_STROBE) ||
                (state_nxt == ST_W_HOLD);
        end
    end

    // address and data are held for the whole access
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr <= '0;
            mem_data_out <= '0;
        end else if (accept) begin
            mem_addr <= req_addr;
            if (req_write) begin
                mem_data_out <= req_wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= ((state_r == ST_R_ACCESS) && (state_nxt == ST_R_RELEASE)) ||
                ((state_r == ST_W_HOLD) && (state_nxt == ST_IDLE));
            if ((state_r == ST_R_ACCESS) && (state_nxt == ST_R_RELEASE)) begin
                rsp_rdata <= mem_data_in;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_select_combo: assert property (
        (!chip_select_first_n && chip_select_second_hi && !chip_select_third_n) ||
        (chip_select_first_n && !chip_select_second_hi && chip_select_third_n))
        else $error("chip selects in a mixed state");
    chk_strobe_needs_sel: assert property (
        !write_strobe_n |-> !chip_select_first_n && mem_data_oe && out_enable_n)
        else $error("write strobe low without selection or data");
    chk_write_end_strobe: assert property (
        $rose(write_strobe_n) |-> !chip_select_first_n ##1 chip_select_first_n)
        else $error("write not ended by the strobe alone");
    chk_write_data_held: assert property (
        $rose(write_strobe_n) |-> mem_data_oe && $stable(mem_data_out))
        else $error("write data moved at write end");
    chk_write_addr_held: assert property (
        $rose(mem_data_oe) |=> $stable(mem_addr)[*2])
        else $error("address moved during write");
    chk_write_cycle_len: assert property (
        $rose(mem_data_oe) |-> write_strobe_n ##1 !write_strobe_n ##1
        (write_strobe_n && mem_data_oe) ##1 !mem_data_oe)
        else $error("write phases not one cycle each");
    chk_read_answer: assert property (
        $fell(out_enable_n) |=> rsp_valid && out_enable_n && chip_select_first_n)
        else $error("read answer not one cycle after enable");
    chk_read_strobe_high: assert property (
        !out_enable_n |-> write_strobe_n && !mem_data_oe)
        else $error("strobe or data driven during read");
    chk_power_gate: assert property (
        !power_ready |-> chip_select_first_n && !req_ready)
        else $error("access before power-up wait");

    cov_read: cover property ($fell(out_enable_n) ##1 rsp_valid);
    cov_write: cover property ($fell(write_strobe_n) ##2 rsp_valid);
    cov_back_to_back: cover property (rsp_valid ##[1:3] $fell(chip_select_first_n));
    cov_power_up: cover property ($rose(power_ready));

endmodule : sac_ctrl

/* File: design/sac_pkg.sv */
/*
 * Package for the asynchronous static memory access controller:
 * bus widths, pin timing figures and the cycle counts derived from them.
 * Assumes a single 10 MHz core clock.
 */
package sac_pkg;

    localparam int ADDR_W = 17;
    localparam int DATA_W = 24;
    localparam int TMR_W = 10;

    localparam int CLK_PERIOD_PS = 100000;

    // pin timing figures, in picoseconds; the power-up wait in microseconds
    localparam int ADDRESS_ACCESS_TIME_PS = 10000;
    localparam int ADDRESS_CHANGE_DATA_HOLD_PS = 3000;
    localparam int READ_CYCLE_TIME_PS = 10000;
    localparam int SELECT_TO_DATA_VALID_PS = 10000;
    localparam int OUTPUT_DRIVE_TO_VALID_PS = 5000;
    localparam int OUTPUT_FLOAT_PS = 5000;
    localparam int DESELECT_TO_SLEEP_PS = 10000;
    localparam int WRITE_CYCLE_TIME_PS = 10000;
    localparam int SELECT_TO_WRITE_END_PS = 7000;
    localparam int ADDRESS_SETUP_TO_WRITE_END_PS = 7000;
    localparam int ADDRESS_SETUP_TO_WRITE_START_PS = 0;
    localparam int WRITE_STROBE_PULSE_WIDTH_PS = 7000;
    localparam int WRITE_DATA_SETUP_PS = 5500;
    localparam int WRITE_DATA_HOLD_PS = 0;
    localparam int STROBE_LOW_TO_FLOAT_PS = 5000;
    localparam int SUPPLY_TO_FIRST_ACCESS_US = 100;

    // least time rounded up to whole cycles, never below one
    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    localparam logic [TMR_W-1:0] SETUP_CYC = TMR_W'(cyc_up(ADDRESS_SETUP_TO_WRITE_START_PS));
    localparam logic [TMR_W-1:0] STROBE_CYC = TMR_W'(cyc_up(max2(
        max2(WRITE_STROBE_PULSE_WIDTH_PS, SELECT_TO_WRITE_END_PS),
        max2(ADDRESS_SETUP_TO_WRITE_END_PS, STROBE_LOW_TO_FLOAT_PS + WRITE_DATA_SETUP_PS))));
    localparam logic [TMR_W-1:0] HOLD_CYC = TMR_W'(cyc_up(WRITE_DATA_HOLD_PS));
    localparam logic [TMR_W-1:0] ACCESS_CYC = TMR_W'(cyc_up(max2(
        max2(ADDRESS_ACCESS_TIME_PS, SELECT_TO_DATA_VALID_PS),
        max2(OUTPUT_DRIVE_TO_VALID_PS, READ_CYCLE_TIME_PS))));
    localparam logic [TMR_W-1:0] RELEASE_CYC = TMR_W'(cyc_up(max2(
        max2(OUTPUT_FLOAT_PS, DESELECT_TO_SLEEP_PS), ADDRESS_CHANGE_DATA_HOLD_PS)));
    localparam logic [TMR_W-1:0] POWER_CYC = TMR_W'(cyc_up(SUPPLY_TO_FIRST_ACCESS_US * 1000000));

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_W_SETUP = 3'h1,
        ST_W_STROBE = 3'h3,
        ST_W_HOLD = 3'h2,
        ST_R_ACCESS = 3'h4,
        ST_R_RELEASE = 3'h6
    } sac_state_e;

endpackage : sac_pkg

/* File: design/sac_tmr_if.sv */
/*
 * Interface between the access sequencer and its phase/power-up timer.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface sac_tmr_if;
    import sac_pkg::*;
    logic load;
    logic [TMR_W-1:0] load_val;
    logic done;
    logic pwr_ok;
    modport ctl (output load, output load_val, input done, input pwr_ok);
    modport tmr (input load, input load_val, output done, output pwr_ok);
endinterface : sac_tmr_if

/* File: design/sac_timer.sv */
/*
 * Phase timer and power-up wait counter for the access sequencer.
 * Assumes reset release marks the moment the supply is up.
 */
`timescale 1ns/1ps
module sac_timer
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    sac_tmr_if.tmr tif
);
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] pwr_cnt_r;
    logic pwr_ok_r;

    // a load of n-1 lets the phase last n cycles
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else if (tif.load) begin
            cnt_r <= tif.load_val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - TMR_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_cnt_r <= '0;
            pwr_ok_r <= 1'b0;
        end else if (!pwr_ok_r) begin
            pwr_cnt_r <= pwr_cnt_r + TMR_W'(1);
            pwr_ok_r <= (pwr_cnt_r == POWER_CYC - TMR_W'(1));
        end
    end

    assign tif.done = (cnt_r == '0);
    assign tif.pwr_ok = pwr_ok_r;

    chk_power_wait_len: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(pwr_ok_r) |-> pwr_cnt_r == POWER_CYC)
        else $error("power-up wait not equal to its count");

endmodule : sac_timer

/* File: dv/sac_mem_model.sv */
/*
 * Behavioural model of the 128K x 24 asynchronous static memory.
 * Assumes the controller's data pins are resolved here from mem_data_oe.
 */
`timescale 1ns/1ps
module sac_mem_model
    import sac_pkg::*;
#(
    parameter int RD_DELAY_NS = 0
)
(
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second_hi,
    input wire logic chip_select_third_n,
    input wire logic out_enable_n,
    input wire logic write_strobe_n,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic mem_data_oe,
    output logic [DATA_W-1:0] mem_data_in,
    output int viol_cnt
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last_v;
    logic drv_late;
    realtime t_addr, t_data, t_wr, t_sel;
    wire sel = !chip_select_first_n && chip_select_second_hi && !chip_select_third_n;
    wire wr_act = sel && !write_strobe_n;
    wire rd_drv = sel && !out_enable_n && write_strobe_n;
    wire [DATA_W-1:0] rd_w = mem[mem_addr];

    assign #(RD_DELAY_NS) drv_late = rd_drv;

    initial viol_cnt = 0;
    always @(mem_addr) t_addr = $realtime;
    always @(mem_data_out or mem_data_oe) t_data = $realtime;
    always @(posedge sel) t_sel = $realtime;
    always @(posedge wr_act) t_wr = $realtime;

    // write ends on the first select or strobe to leave its level
    always @(negedge wr_act) begin
        if ($realtime - t_data < 5.5 || !mem_data_oe) viol_cnt++;
        if ($realtime - t_addr < 7.0) viol_cnt++;
        if ($realtime - t_wr < 7.0 || $realtime - t_sel < 7.0) viol_cnt++;
        mem[mem_addr] = mem_data_out;
    end

    always @(rd_w or rd_drv or drv_late or mem_data_oe or mem_data_out) begin
        if (mem_data_oe) last_v = mem_data_out;
        else if (rd_drv && drv_late) last_v = rd_w;
    end

    // released pins show the inverse of the last value, never a stale copy
    always @* begin
        if (mem_data_oe) mem_data_in = mem_data_out;
        else if (rd_drv && drv_late) mem_data_in = rd_w;
        else mem_data_in = ~last_v;
    end
endmodule : sac_mem_model

/* File: dv/tb_top.sv */
/*
 * Self-checking bench for sac_ctrl with a memory model on the far side.
 * Assumes a 10 MHz core clock and reset held 16 cycles.
 */
`timescale 1ns/1ps
module tb_top;
    import sac_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic req_ready, rsp_valid, power_ready, mem_data_oe;
    logic [DATA_W-1:0] rsp_rdata, mem_data_out, mem_data_in, last_rd;
    logic [ADDR_W-1:0] mem_addr;
    logic cs1_n, cs2, cs3_n, out_enable_n, write_strobe_n, we_prev;
    int viol_cnt, error_cnt = 0, samples_checked = 0, n, lat;
    wire sel = !cs1_n && cs2 && !cs3_n;

    always #50 core_clk = ~core_clk;

    sac_ctrl uut (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .power_ready(power_ready), .mem_addr(mem_addr), .chip_select_first_n(cs1_n),
        .chip_select_second_hi(cs2), .chip_select_third_n(cs3_n),
        .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in));

    sac_mem_model #(.RD_DELAY_NS(9)) mem_i (.mem_addr(mem_addr),
        .chip_select_first_n(cs1_n), .chip_select_second_hi(cs2),
        .chip_select_third_n(cs3_n), .out_enable_n(out_enable_n),
        .write_strobe_n(write_strobe_n), .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in), .viol_cnt(viol_cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // pin relations seen every cycle
    always @(posedge core_clk) begin
        if (reset_n) begin
            if (!write_strobe_n) chk(sel, 1, "strobe low while deselected");
            if (!out_enable_n) chk({mem_data_oe, write_strobe_n}, 2'h1, "read drive");
            if (!we_prev && write_strobe_n) chk(sel, 1, "deselect at strobe rise");
        end
        we_prev <= write_strobe_n;
    end

    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic seen_sel;
        seen_sel = 1'b0;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        for (n = 0; n < 1200; n++) begin
            @(posedge core_clk);
            if (n < 1000) seen_sel |= sel;
            if (req_ready === 1'b1) break;
        end
        chk(seen_sel && n >= 1000, 0, "pins active during power wait");
        if (n == 1200) begin
            chk(0, 1, "request never taken");
            give_verdict();
        end
    endtask : issue

    task automatic wait_rsp();
        for (lat = 1; lat < 9; lat++) begin
            @(posedge core_clk);
            if (rsp_valid === 1'b1) return;
        end
        chk(0, 1, "no answer");
        give_verdict();
    endtask : wait_rsp

    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        issue(wr, a, d);
        req_valid <= 1'b0;
        wait_rsp();
        chk(lat, wr ? 4 : 2, "answer latency");
        chk(rsp_rdata, wr ? last_rd : d, "read word");
        if (!wr) last_rd = d;
    endtask : access

    task automatic t_power();
        issue(1'b1, 17'h00000, 24'ha5c3e1);
        chk(n >= 1000, 1, "first access too early");
        chk(power_ready, 1, "power ready after wait");
        req_valid <= 1'b0;
        wait_rsp();
        access(1'b0, 17'h00000, 24'ha5c3e1);
    endtask : t_power

    task automatic t_walk();
        logic [ADDR_W-1:0] addrs [3] = '{17'h1ffff, 17'h00001, 17'h10000};
        logic [DATA_W-1:0] pats [3] = '{24'hffffff, 24'h000001, 24'h800000};
        for (int i = 0; i < 3; i++) access(1'b1, addrs[i], pats[i]);
        for (int i = 0; i < 3; i++) access(1'b0, addrs[i], pats[i]);
    endtask : t_walk

    task automatic t_b2b();
        issue(1'b1, 17'h0abcd, 24'h5a5a5a);
        issue(1'b0, 17'h0abcd, 24'h000000);
        req_valid <= 1'b0;
        wait_rsp();
        chk(lat, 2, "read after write latency");
        chk(rsp_rdata, 24'h5a5a5a, "read after write");
        last_rd = 24'h5a5a5a;
    endtask : t_b2b

    task automatic t_reset();
        issue(1'b1, 17'h00002, 24'h123456);
        req_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b0;
        #1;
        chk({cs1_n, cs2, cs3_n, write_strobe_n, mem_data_oe}, 5'h16, "pins in reset");
        chk(power_ready, 0, "power ready in reset");
        // reset clears the held read word
        last_rd = '0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        access(1'b1, 17'h00003, 24'h654321);
        chk(n >= 1000, 1, "access before power wait");
        access(1'b0, 17'h00003, 24'h654321);
    endtask : t_reset

    initial begin
        last_rd = '0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        t_power();
        t_walk();
        t_b2b();
        t_reset();
        chk(viol_cnt, 0, "write timing at memory pins");
        give_verdict();
    end
endmodule : tb_top
